// ==== src/operand_field_pkg.sv ====
// constants and types shared by the operand field decoder
package operand_field_pkg;

    // address width and register file size
    localparam int ADDR_W = 32;
    localparam int GPR_COUNT = 8;
    localparam int GPR_FILE_W = 256;

    // field positions within the mode/register byte
    localparam int MODE_MSB = 7;
    localparam int MODE_LSB = 6;
    localparam int REG_MSB = 5;
    localparam int REG_LSB = 3;
    localparam int RM_MSB = 2;
    localparam int RM_LSB = 0;

    // field positions within the scale-index-base byte
    localparam int SCALE_MSB = 7;
    localparam int SCALE_LSB = 6;
    localparam int INDEX_MSB = 5;
    localparam int INDEX_LSB = 3;
    localparam int BASE_MSB = 2;
    localparam int BASE_LSB = 0;

    // addressing mode field codes
    localparam logic [1:0] MODE_NO_DISP = 2'h0;
    localparam logic [1:0] MODE_BYTE_DISP = 2'h1;
    localparam logic [1:0] MODE_DWORD_DISP = 2'h2;
    localparam logic [1:0] MODE_REGISTER = 2'h3;

    // special register codes in address forms
    localparam logic [2:0] RM_SIB_PRESENT = 3'h4;
    localparam logic [2:0] INDEX_NONE = 3'h4;
    localparam logic [2:0] BASE_STACK = 3'h4;
    localparam logic [2:0] BASE_FRAME = 3'h5;
    localparam logic [2:0] GPR_ESP = 3'h4;
    localparam logic [2:0] GPR_EBP = 3'h5;
    localparam logic [1:0] SCALE_ONE = 2'h0;

    // register code layout: top bit picks the high byte for byte operands
    localparam int HIGH_BYTE_BIT = 2;

    // segment selector codes
    localparam logic [2:0] SEG_CODE_ES = 3'h0;
    localparam logic [2:0] SEG_CODE_CS = 3'h1;
    localparam logic [2:0] SEG_CODE_SS = 3'h2;
    localparam logic [2:0] SEG_CODE_DS = 3'h3;
    localparam logic [2:0] SEG_CODE_FS = 3'h4;
    localparam logic [2:0] SEG_CODE_GS = 3'h5;

    // displacement lengths in bytes
    localparam logic [2:0] DISP_LEN_NONE = 3'h0;
    localparam logic [2:0] DISP_LEN_BYTE = 3'h1;
    localparam logic [2:0] DISP_LEN_WORD = 3'h2;
    localparam logic [2:0] DISP_LEN_DWORD = 3'h4;

    // scale factors
    localparam logic [3:0] SCALE_FACTOR_BASE = 4'h1;

    typedef enum logic [2:0] {seg_es, seg_cs, seg_ss, seg_ds, seg_fs, seg_gs, seg_none} seg_t;
    typedef enum logic [1:0] {part_low_byte, part_high_byte, part_word, part_dword} part_t;

endpackage : operand_field_pkg

// ==== src/gpr_code_decoder.sv ====
// maps a 3-bit register code to a general register and the part used
`timescale 1ns/1ps
module gpr_code_decoder (
    // register code and operand size
    input wire logic [2:0] code,
    input wire logic width_bit,
    input wire logic operand_size_32,
    // selected register
    output logic [2:0] gpr_index,
    output operand_field_pkg::part_t part
);

    // byte codes 4..7 reach the high byte of the first four registers
    always_comb
    begin
        if (!width_bit)
        begin
            gpr_index = {1'b0, code[operand_field_pkg::HIGH_BYTE_BIT-1:0]}; // RULE2
            part = code[operand_field_pkg::HIGH_BYTE_BIT] ? operand_field_pkg::part_high_byte
                                                          : operand_field_pkg::part_low_byte;
        end
        else
        begin
            gpr_index = code; // RULE2
            part = operand_size_32 ? operand_field_pkg::part_dword : operand_field_pkg::part_word;
        end
    end

endmodule : gpr_code_decoder

// ==== src/seg_code_decoder.sv ====
// maps a 2-bit or 3-bit segment selector code to a segment register
`timescale 1ns/1ps
module seg_code_decoder (
    // selector code, high bit ignored in two-bit form
    input wire logic [2:0] code,
    input wire logic two_bit,
    // selected segment
    output operand_field_pkg::seg_t seg,
    output logic seg_valid
);

    logic [2:0] code_eff;

    // the two-bit codes share the low four entries of the three-bit map
    assign code_eff = two_bit ? {1'b0, code[1:0]} : code;

    always_comb
    begin
        seg_valid = 1'b1;
        case (code_eff)
            operand_field_pkg::SEG_CODE_ES: seg = operand_field_pkg::seg_es; // RULE3
            operand_field_pkg::SEG_CODE_CS: seg = operand_field_pkg::seg_cs; // RULE3
            operand_field_pkg::SEG_CODE_SS: seg = operand_field_pkg::seg_ss; // RULE3
            operand_field_pkg::SEG_CODE_DS: seg = operand_field_pkg::seg_ds; // RULE3
            operand_field_pkg::SEG_CODE_FS: seg = operand_field_pkg::seg_fs; // RULE4
            operand_field_pkg::SEG_CODE_GS: seg = operand_field_pkg::seg_gs; // RULE4
            default:
            begin
                seg = operand_field_pkg::seg_none; // RULE4
                seg_valid = 1'b0;
            end
        endcase
    end

endmodule : seg_code_decoder

// ==== src/operand_field_decoder.sv ====
// operand field decoder: register, segment and scale-index-base address decode
//
// How it works
// RULE1: addressing mode 11 makes the register/memory field a register code decoded like reg.
// RULE2: the reg field picks AL..BH for byte operands, AX..DI or EAX..EDI for word operands.
// RULE3: the two-bit segment selector maps 00 ES, 01 CS, 10 SS, 11 DS.
// RULE4: the three-bit segment selector adds 100 FS and 101 GS; 110 and 111 select nothing.
// RULE5: the scale field multiplies the index by 1, 2, 4 or 8 for codes 00 to 11.
// RULE6: the index field names EAX..EDI, except code 100 which means no index at all.
// RULE7: with no index the scale must be 00, otherwise the address is flagged undefined.
// RULE8: mode comes from mode/register bits 7:6, base from scale-index-base bits 2:0.
// RULE9: mode 00 adds base and scaled index in DS; base 100 is ESP in SS; 101 is a dword instead.
// RULE10: modes 01 and 10 add a byte or dword displacement; bases 100 and 101 use SS, others DS.
// RULE11: displacements are 8, 16 or 32 bits wide, taken from the instruction stream.
// RULE12: a byte displacement is sign extended and the address sums wrap at 32 bits.
`timescale 1ns/1ps
module operand_field_decoder (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // instruction bytes from the fetch stream
    input wire logic decode_strobe,
    input wire logic [7:0] mode_register_byte,
    input wire logic [7:0] scale_index_base_byte,
    input wire logic [31:0] displacement_bytes,
    input wire logic [1:0] two_bit_segment_selector,
    input wire logic [2:0] three_bit_segment_selector,
    // operating sizes
    input wire logic width_bit,
    input wire logic operand_size_32,
    input wire logic address_size_32,
    // register file read port, register n at bits 32n+31..32n
    input wire logic [255:0] gpr_file,
    // register operand selection
    output logic result_valid,
    output logic [2:0] reg_gpr,
    output operand_field_pkg::part_t reg_part,
    output logic rm_is_register,
    output logic [2:0] rm_gpr,
    output operand_field_pkg::part_t rm_part,
    // segment selection
    output operand_field_pkg::seg_t seg2_sel,
    output operand_field_pkg::seg_t seg3_sel,
    output logic seg3_valid,
    // scale-index-base address
    output logic sib_form,
    output logic base_used,
    output logic [2:0] base_gpr,
    output logic index_used,
    output logic [2:0] index_gpr,
    output logic [3:0] scale_factor,
    output logic [2:0] disp_len,
    output logic [31:0] disp_value,
    output logic [31:0] base_value,
    output logic [31:0] scaled_index,
    output logic [31:0] ea,
    output operand_field_pkg::seg_t ea_segment,
    output logic ea_defined
);

    // field extraction
    logic [1:0] addressing_mode_field;
    logic [2:0] register_operand_field;
    logic [2:0] register_memory_field;
    logic [1:0] scale_field;
    logic [2:0] index_field;
    logic [2:0] base_field;
    logic [7:0] byte_displacement;
    logic [15:0] word_displacement;
    logic [31:0] dword_displacement;

    // decoded values before the output flops
    logic [2:0] reg_gpr_next;
    operand_field_pkg::part_t reg_part_next;
    logic [2:0] rm_gpr_next;
    operand_field_pkg::part_t rm_part_next;
    operand_field_pkg::seg_t seg2_next;
    operand_field_pkg::seg_t seg3_next;
    logic seg3_valid_next;
    logic sib_next;
    logic base_used_next;
    logic index_used_next;
    logic [2:0] disp_len_next;
    logic [31:0] disp_next;
    logic [31:0] base_value_next;
    logic [31:0] index_value;
    logic [31:0] scaled_next;
    logic [3:0] scale_factor_next;
    operand_field_pkg::seg_t ea_seg_next;
    logic ea_defined_next;

    // output flops
    logic result_valid_reg;
    logic [2:0] reg_gpr_reg;
    operand_field_pkg::part_t reg_part_reg;
    logic rm_is_register_reg;
    logic [2:0] rm_gpr_reg;
    operand_field_pkg::part_t rm_part_reg;
    operand_field_pkg::seg_t seg2_reg;
    operand_field_pkg::seg_t seg3_reg;
    logic seg3_valid_reg;
    logic sib_reg;
    logic base_used_reg;
    logic [2:0] base_gpr_reg;
    logic index_used_reg;
    logic [2:0] index_gpr_reg;
    logic [3:0] scale_factor_reg;
    logic [2:0] disp_len_reg;
    logic [31:0] disp_reg;
    logic [31:0] base_value_reg;
    logic [31:0] scaled_reg;
    logic [31:0] ea_reg;
    operand_field_pkg::seg_t ea_seg_reg;
    logic ea_defined_reg;

    // fields at their fixed byte positions
    assign addressing_mode_field =
        mode_register_byte[operand_field_pkg::MODE_MSB:operand_field_pkg::MODE_LSB]; // RULE8
    assign register_operand_field =
        mode_register_byte[operand_field_pkg::REG_MSB:operand_field_pkg::REG_LSB];
    assign register_memory_field =
        mode_register_byte[operand_field_pkg::RM_MSB:operand_field_pkg::RM_LSB];
    assign scale_field =
        scale_index_base_byte[operand_field_pkg::SCALE_MSB:operand_field_pkg::SCALE_LSB];
    assign index_field =
        scale_index_base_byte[operand_field_pkg::INDEX_MSB:operand_field_pkg::INDEX_LSB];
    assign base_field =
        scale_index_base_byte[operand_field_pkg::BASE_MSB:operand_field_pkg::BASE_LSB]; // RULE8
    assign byte_displacement = displacement_bytes[7:0]; // RULE11
    assign word_displacement = displacement_bytes[15:0]; // RULE11
    assign dword_displacement = displacement_bytes; // RULE11

    // one decoder each for reg and register/memory, same mapping for both
    gpr_code_decoder reg_decoder (
        .code(register_operand_field),
        .width_bit(width_bit),
        .operand_size_32(operand_size_32),
        .gpr_index(reg_gpr_next),
        .part(reg_part_next)
    );

    gpr_code_decoder rm_decoder (
        .code(register_memory_field), // RULE1
        .width_bit(width_bit),
        .operand_size_32(operand_size_32),
        .gpr_index(rm_gpr_next),
        .part(rm_part_next)
    );

    // segment selector decoders
    seg_code_decoder seg2_decoder (
        .code({1'b0, two_bit_segment_selector}),
        .two_bit(1'b1),
        .seg(seg2_next),
        .seg_valid()
    );

    seg_code_decoder seg3_decoder (
        .code(three_bit_segment_selector),
        .two_bit(1'b0),
        .seg(seg3_next),
        .seg_valid(seg3_valid_next)
    );

    // the escape code in register/memory only means sib with 32-bit addressing
    assign sib_next = address_size_32
                      && (addressing_mode_field != operand_field_pkg::MODE_REGISTER)
                      && (register_memory_field == operand_field_pkg::RM_SIB_PRESENT);

    // index selection; code 100 contributes nothing
    assign index_used_next = sib_next && (index_field != operand_field_pkg::INDEX_NONE); // RULE6
    assign index_value = index_used_next ? gpr_file[{index_field, 5'h00} +: 32] : 32'h0; // RULE6
    assign scaled_next = index_value << scale_field; // RULE5
    assign scale_factor_next = operand_field_pkg::SCALE_FACTOR_BASE << scale_field; // RULE5

    // no base register in mode 00 with base 101, a dword stands there instead
    assign base_used_next = sib_next
                            && !((addressing_mode_field == operand_field_pkg::MODE_NO_DISP)
                                 && (base_field == operand_field_pkg::BASE_FRAME)); // RULE9
    assign base_value_next = base_used_next ? gpr_file[{base_field, 5'h00} +: 32] : 32'h0;

    // displacement width and value by mode
    always_comb
    begin
        disp_len_next = operand_field_pkg::DISP_LEN_NONE;
        disp_next = 32'h0;
        case (addressing_mode_field)
            operand_field_pkg::MODE_BYTE_DISP:
            begin
                disp_len_next = operand_field_pkg::DISP_LEN_BYTE; // RULE10
                disp_next = {{24{byte_displacement[7]}}, byte_displacement}; // RULE12
            end
            operand_field_pkg::MODE_DWORD_DISP:
            begin
                if (address_size_32)
                begin
                    disp_len_next = operand_field_pkg::DISP_LEN_DWORD; // RULE10
                    disp_next = dword_displacement;
                end
                else
                begin
                    disp_len_next = operand_field_pkg::DISP_LEN_WORD; // RULE11
                    disp_next = {{16{word_displacement[15]}}, word_displacement};
                end
            end
            operand_field_pkg::MODE_NO_DISP:
            begin
                if (sib_next && (base_field == operand_field_pkg::BASE_FRAME))
                begin
                    disp_len_next = operand_field_pkg::DISP_LEN_DWORD; // RULE9
                    disp_next = dword_displacement;
                end
            end
            default:
            begin
                disp_len_next = operand_field_pkg::DISP_LEN_NONE;
                disp_next = 32'h0;
            end
        endcase
    end

    // default segment: stack bases go to SS, mode 00 frame code is DS
    always_comb
    begin
        ea_seg_next = operand_field_pkg::seg_ds; // RULE9
        if (base_field == operand_field_pkg::BASE_STACK)
        begin
            ea_seg_next = operand_field_pkg::seg_ss; // RULE9
        end
        else if ((base_field == operand_field_pkg::BASE_FRAME)
                 && (addressing_mode_field != operand_field_pkg::MODE_NO_DISP))
        begin
            ea_seg_next = operand_field_pkg::seg_ss; // RULE10
        end
    end

    // scale other than 00 without an index leaves the address undefined
    assign ea_defined_next = sib_next
                             && !((index_field == operand_field_pkg::INDEX_NONE)
                                  && (scale_field != operand_field_pkg::SCALE_ONE)); // RULE7

    // result valid strobe, one cycle after the request
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            result_valid_reg <= 1'b0;
        else
            result_valid_reg <= decode_strobe;
    end

    // register operand outputs, held until the next request
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_gpr_reg <= 3'h0;
            reg_part_reg <= operand_field_pkg::part_low_byte;
            rm_is_register_reg <= 1'b0;
            rm_gpr_reg <= 3'h0;
            rm_part_reg <= operand_field_pkg::part_low_byte;
        end
        else if (decode_strobe)
        begin
            reg_gpr_reg <= reg_gpr_next; // RULE2
            reg_part_reg <= reg_part_next;
            rm_is_register_reg <= (addressing_mode_field == operand_field_pkg::MODE_REGISTER); // RULE1
            rm_gpr_reg <= rm_gpr_next;
            rm_part_reg <= rm_part_next;
        end
    end

    // segment selector outputs
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            seg2_reg <= operand_field_pkg::seg_es;
            seg3_reg <= operand_field_pkg::seg_es;
            seg3_valid_reg <= 1'b0;
        end
        else if (decode_strobe)
        begin
            seg2_reg <= seg2_next; // RULE3
            seg3_reg <= seg3_next; // RULE4
            seg3_valid_reg <= seg3_valid_next;
        end
    end

    // address outputs; the sum is cut to 32 bits so it wraps
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sib_reg <= 1'b0;
            base_used_reg <= 1'b0;
            base_gpr_reg <= 3'h0;
            index_used_reg <= 1'b0;
            index_gpr_reg <= 3'h0;
            scale_factor_reg <= operand_field_pkg::SCALE_FACTOR_BASE;
            disp_len_reg <= operand_field_pkg::DISP_LEN_NONE;
            disp_reg <= 32'h0;
            base_value_reg <= 32'h0;
            scaled_reg <= 32'h0;
            ea_reg <= 32'h0;
            ea_seg_reg <= operand_field_pkg::seg_ds;
            ea_defined_reg <= 1'b0;
        end
        else if (decode_strobe)
        begin
            sib_reg <= sib_next;
            base_used_reg <= base_used_next;
            base_gpr_reg <= base_field; // RULE8
            index_used_reg <= index_used_next;
            index_gpr_reg <= index_field;
            scale_factor_reg <= scale_factor_next;
            disp_len_reg <= disp_len_next;
            disp_reg <= disp_next;
            base_value_reg <= base_value_next;
            scaled_reg <= scaled_next;
            ea_reg <= base_value_next + scaled_next + disp_next; // RULE12
            ea_seg_reg <= ea_seg_next;
            ea_defined_reg <= ea_defined_next;
        end
    end

    // outputs straight from the flops
    assign result_valid = result_valid_reg;
    assign reg_gpr = reg_gpr_reg;
    assign reg_part = reg_part_reg;
    assign rm_is_register = rm_is_register_reg;
    assign rm_gpr = rm_gpr_reg;
    assign rm_part = rm_part_reg;
    assign seg2_sel = seg2_reg;
    assign seg3_sel = seg3_reg;
    assign seg3_valid = seg3_valid_reg;
    assign sib_form = sib_reg;
    assign base_used = base_used_reg;
    assign base_gpr = base_gpr_reg;
    assign index_used = index_used_reg;
    assign index_gpr = index_gpr_reg;
    assign scale_factor = scale_factor_reg;
    assign disp_len = disp_len_reg;
    assign disp_value = disp_reg;
    assign base_value = base_value_reg;
    assign scaled_index = scaled_reg;
    assign ea = ea_reg;
    assign ea_segment = ea_seg_reg;
    assign ea_defined = ea_defined_reg;

    // checks on the decoded outputs
    rm_register_sel_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE1
        decode_strobe && (addressing_mode_field == operand_field_pkg::MODE_REGISTER)
        && width_bit |=> rm_is_register_reg && (rm_gpr_reg == $past(register_memory_field)))
        else $error("register/memory field not taken as register");

    reg_high_byte_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE2
        decode_strobe && !width_bit && register_operand_field[operand_field_pkg::HIGH_BYTE_BIT]
        |=> (reg_part_reg == operand_field_pkg::part_high_byte)
            && (reg_gpr_reg[operand_field_pkg::HIGH_BYTE_BIT] == 1'b0))
        else $error("byte code not mapped to high byte");

    seg2_ss_sel_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE3
        decode_strobe && (two_bit_segment_selector == operand_field_pkg::SEG_CODE_SS[1:0])
        |=> seg2_reg == operand_field_pkg::seg_ss)
        else $error("two-bit selector 10 not SS");

    seg3_undefined_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE4
        decode_strobe |=> (seg3_valid_reg == ($past(three_bit_segment_selector) <= 3'h5)))
        else $error("three-bit selector validity wrong");

    scale_by_eight_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE5
        decode_strobe && (scale_field == 2'h3)
        |=> (scale_factor_reg == 4'h8) && (scaled_reg[2:0] == 3'h0))
        else $error("scale 11 not x8");

    no_index_zero_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE6
        decode_strobe && (index_field == operand_field_pkg::INDEX_NONE)
        |=> !index_used_reg && (scaled_reg == 32'h0))
        else $error("index 100 contributed");

    undefined_scale_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE7
        decode_strobe && sib_next && (index_field == operand_field_pkg::INDEX_NONE)
        |=> (ea_defined_reg == ($past(scale_field) == operand_field_pkg::SCALE_ONE)))
        else $error("undefined address not flagged");

    base_field_bits_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE8
        decode_strobe |=> base_gpr_reg == $past(scale_index_base_byte[2:0]))
        else $error("base not taken from bits 2:0");

    mode0_dword_base_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE9
        decode_strobe && sib_next && (addressing_mode_field == operand_field_pkg::MODE_NO_DISP)
        && (base_field == operand_field_pkg::BASE_FRAME)
        |=> !base_used_reg && (ea_seg_reg == operand_field_pkg::seg_ds)
            && (disp_reg == $past(displacement_bytes)))
        else $error("mode 00 base 101 wrong");

    frame_base_ss_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE10
        decode_strobe && sib_next && (addressing_mode_field == operand_field_pkg::MODE_BYTE_DISP)
        && (base_field == operand_field_pkg::BASE_FRAME)
        |=> base_used_reg && (ea_seg_reg == operand_field_pkg::seg_ss))
        else $error("frame base not in SS");

    byte_disp_sext_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
        decode_strobe && (addressing_mode_field == operand_field_pkg::MODE_BYTE_DISP)
        |=> (disp_len_reg == operand_field_pkg::DISP_LEN_BYTE)
            && (disp_reg == {{24{$past(byte_displacement[7])}}, $past(byte_displacement)}))
        else $error("byte displacement not sign extended");

    ea_wrap_sum_a: assert property (@(posedge ref_clk) disable iff (rst) // RULE12
        result_valid_reg |-> ea_reg == 32'(base_value_reg + scaled_reg + disp_reg))
        else $error("effective address sum wrong");

endmodule : operand_field_decoder

// ==== verif/gpr_model.sv ====
// register file model feeding the decoder read port
`timescale 1ns/1ps
module gpr_model (
    // register contents
    output logic [255:0] gpr_file
);
    // register n holds n times 11111111, so every register reads differently
    always_comb
    begin
        for (int n = 0; n < 8; n++)
        begin
            gpr_file[32*n +: 32] = 32'h11111111 * n;
        end
    end
endmodule : gpr_model

// ==== verif/tb_operand_field_decoder.sv ====
// self-checking bench for the operand field decoder
`timescale 1ns/1ps
module tb_operand_field_decoder;
    logic ref_clk = 1'h0;
    logic rst = 1'h1;
    logic decode_strobe = 1'h0, width_bit = 1'h0, operand_size_32 = 1'h0, address_size_32 = 1'h0;
    logic [7:0] mode_register_byte = 8'h0, scale_index_base_byte = 8'h0;
    logic [31:0] displacement_bytes = 32'h0;
    logic [1:0] two_bit_segment_selector = 2'h0;
    logic [2:0] three_bit_segment_selector = 3'h0;
    logic [255:0] gpr_file;
    logic result_valid, rm_is_register, seg3_valid, sib_form, base_used, index_used, ea_defined;
    logic [2:0] reg_gpr, rm_gpr, base_gpr, index_gpr, disp_len;
    logic [3:0] scale_factor;
    logic [31:0] disp_value, base_value, scaled_index, ea;
    operand_field_pkg::part_t reg_part, rm_part;
    operand_field_pkg::seg_t seg2_sel, seg3_sel, ea_segment;
    int bad_count = 0, comparisons = 0, cycles = 0;

    gpr_model i_gpr_model (.gpr_file);
    operand_field_decoder i_operand_field_decoder (.ref_clk, .rst, .decode_strobe,
        .mode_register_byte, .scale_index_base_byte, .displacement_bytes,
        .two_bit_segment_selector, .three_bit_segment_selector, .width_bit,
        .operand_size_32, .address_size_32, .gpr_file, .result_valid, .reg_gpr, .reg_part,
        .rm_is_register, .rm_gpr, .rm_part, .seg2_sel, .seg3_sel, .seg3_valid, .sib_form,
        .base_used, .base_gpr, .index_used, .index_gpr, .scale_factor, .disp_len,
        .disp_value, .base_value, .scaled_index, .ea, .ea_segment, .ea_defined);

    // 40 MHz clock and a cycle ceiling well above the ~190 cycles needed
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 1000)
        begin
            bad_count++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one strobe; segment codes ride on the low mode/register bits to save ports
    task automatic go(input logic [2:0] cfg, input logic [7:0] mr, input logic [7:0] sb,
        input logic [31:0] d);
        @(posedge ref_clk);
        decode_strobe <= 1'h1;
        mode_register_byte <= mr;
        scale_index_base_byte <= sb;
        displacement_bytes <= d;
        two_bit_segment_selector <= mr[1:0];
        three_bit_segment_selector <= mr[2:0];
        {address_size_32, width_bit, operand_size_32} <= cfg;
        @(posedge ref_clk);
        decode_strobe <= 1'h0;
        #1;
        chk(result_valid, 1'h1);
    endtask : go

    // every code as byte, word and dword register, both fields
    task automatic reg_scan;
        logic [2:0] c;
        logic [1:0] p;
        for (int k = 0; k < 24; k++)
        begin
            c = k[2:0];
            p = k < 8 ? {1'h0, c[2]} : (k < 16 ? 2'h2 : 2'h3);
            go({1'h1, k >= 8, k >= 16}, {2'h3, c, c}, 8'h0, 32'h0);
            chk(rm_is_register, 1'h1);
            chk(rm_gpr, k < 8 ? {1'h0, c[1:0]} : c);
            chk(rm_part, p);
            chk(reg_gpr, k < 8 ? {1'h0, c[1:0]} : c);
            chk(reg_part, p);
        end
    endtask : reg_scan

    task automatic seg_scan;
        for (int c = 0; c < 8; c++)
        begin
            go(3'h7, {5'h0, c[2:0]}, 8'h0, 32'h0);
            chk(seg2_sel, c[1:0]);
            chk(seg3_sel, c < 6 ? c : 6);
            chk(seg3_valid, c < 6);
        end
    endtask : seg_scan

    // all scales and indexes over base EAX, including the illegal no-index scales
    task automatic sib_scan;
        logic [31:0] si;
        for (int k = 0; k < 32; k++)
        begin
            si = (k % 8 == 4) ? 32'h0 : (32'h11111111 * (k % 8)) << (k / 8);
            go(3'h7, 8'h04, {k[4:3], k[2:0], 3'h0}, 32'h0);
            chk(index_used, k % 8 != 4);
            chk(index_gpr, k % 8);
            chk(scale_factor, 1 << (k / 8));
            chk(scaled_index, si);
            chk(ea, si);
            chk(ea_defined, k % 8 != 4 || k < 8);
        end
    endtask : sib_scan

    // every base in modes 00, 01, 10; byte f0 sign extends, base 7 wraps
    task automatic base_scan;
        logic [31:0] dv, bv;
        for (int k = 0; k < 24; k++)
        begin
            dv = k < 8 ? (k == 5 ? 32'h123456f0 : 32'h0) : (k < 16 ? 32'hfffffff0 : 32'h123456f0);
            bv = k == 5 ? 32'h0 : 32'h11111111 * (k % 8);
            go(3'h7, {k[4:3], 6'h0c}, {5'h04, k[2:0]}, 32'h123456f0);
            chk(sib_form, 1'h1);
            chk(base_gpr, k % 8);
            chk(base_used, k != 5);
            chk(disp_len, dv == 0 ? 0 : (k / 8 == 1 ? 1 : 4));
            chk(disp_value, dv);
            chk(base_value, bv);
            chk(ea, bv + dv);
            chk(ea_segment, (k % 8 == 4 || (k % 8 == 5 && k > 7)) ? 2 : 3);
        end
    endtask : base_scan

    // 16-bit addressing: no sib, word displacement sign extended, data held after the pulse
    task automatic word_disp_scan;
        go(3'h3, 8'h84, 8'h00, 32'h12348001);
        chk(sib_form, 1'h0);
        chk(disp_len, 3'h2);
        chk(disp_value, 32'hffff8001);
        chk(ea, 32'hffff8001);
        @(posedge ref_clk);
        #1;
        chk(result_valid, 1'h0);
        chk(disp_value, 32'hffff8001);
    endtask : word_disp_scan

    task automatic report_and_stop;
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : report_and_stop

    initial
    begin
        repeat (12) @(posedge ref_clk);
        rst <= 1'h0;
        reg_scan();
        seg_scan();
        sib_scan();
        base_scan();
        word_disp_scan();
        report_and_stop();
    end
endmodule : tb_operand_field_decoder
